// ==== jae_cfg.svh ====
// constants for the jitter attenuating elastic store
// assumes inclusion by bare name from the package, the elastic store and the oscillator
`ifndef JAE_CFG_SVH
`define JAE_CFG_SVH

// ----------------------------------------
// store geometry
// ----------------------------------------
`define JAE_DEPTH 16
`define JAE_PTR_W 4
`define JAE_WPTR_RST 4'h0
`define JAE_RPTR_RST 4'h7
`define JAE_HALF_FULL 4'h8
`define JAE_OCC_TOP 4'hF
`define JAE_OCC_EMPTY 4'h0

// ----------------------------------------
// rates and oscillator pulling
// ----------------------------------------
`define JAE_SYS_CLK_KHZ 100000
`define JAE_RATE_T1_KBPS 1544
`define JAE_RATE_E1_KBPS 2048
`define JAE_PULL_PPM 130
`define JAE_PPM_SCALE 1000000
`define JAE_STEPS_EACH_SIDE 2
`define JAE_ACC_W 32

// ----------------------------------------
// loop timing
// ----------------------------------------
`define JAE_UPDATE_BITS 64

`endif

// ==== jae_elastic_store.sv ====
// jitter attenuating elastic store: sixteen-bit serial store between the
// jittered line clock and a locally steered output clock
// assumes line_clock_in is a free clock port; flag_clear_n, store_reset_n and
// rate_select are asynchronous pins
`timescale 1ns/100ps
`include "jae_cfg.svh"

module jae_elastic_store #(
	parameter int UPDATE_BITS = `JAE_UPDATE_BITS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic line_clock_in,
	input wire logic line_data_in,
	input wire logic rate_select,
	input wire logic store_reset_n,
	input wire logic flag_clear_n,
	output logic dejittered_clock,
	output logic line_data_out,
	output logic slip_flag
);
	import jae_pkg::*;

	localparam int CNT_W = (UPDATE_BITS > 1) ? $clog2(UPDATE_BITS) : 1;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic jae_ptr_type toGray(input jae_ptr_type b);
		toGray = b ^ (b >> 1);
	endfunction

	function automatic jae_ptr_type fromGray(input jae_ptr_type g);
		jae_ptr_type b;
		b = '0;
		b[`JAE_PTR_W-1] = g[`JAE_PTR_W-1];
		for (int i = `JAE_PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		fromGray = b;
	endfunction

	// accumulator increment for a rate and a pull step
	function automatic jae_word_type freqFor(input logic e1, input jae_step_type step);
		logic signed [63:0] kbps;
		logic signed [63:0] inc;
		logic signed [63:0] stepSize;
		logic signed [63:0] word;
		kbps = e1 ? 64'sd`JAE_RATE_E1_KBPS : 64'sd`JAE_RATE_T1_KBPS;
		inc = (kbps <<< `JAE_ACC_W) / 64'sd`JAE_SYS_CLK_KHZ;
		stepSize = (inc * 64'sd`JAE_PULL_PPM)
			/ (64'sd`JAE_STEPS_EACH_SIDE * 64'sd`JAE_PPM_SCALE);
		word = inc + 64'(step) * stepSize;
		freqFor = word[`JAE_ACC_W-1:0];
	endfunction

	// ----------------------------------------
	// constant reset values
	// ----------------------------------------
	// worked out at elaboration, so every reset branch loads a plain constant
	localparam jae_ptr_type WR_GRAY_RST = toGray(`JAE_WPTR_RST);
	localparam jae_word_type FREQ_RST = freqFor(1'b0, 3'sd0);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// no reset: the first bits read after a store reset are stale
	logic storeMem [`JAE_DEPTH];

	// ----------------------------------------
	// link domain: write side on the falling line clock
	// ----------------------------------------
	logic linkRunMeta_r;
	logic linkRun_r;
	jae_ptr_type wrPtr_r;
	jae_ptr_type wrPtr_nxt;
	jae_ptr_type wrGray_r;

	// store reset reaches the writer through its own two-stage sync
	always_ff @(negedge line_clock_in or posedge sys_rst) begin
		if (sys_rst) begin
			linkRunMeta_r <= 1'b0;
			linkRun_r <= 1'b0;
		end else begin
			linkRunMeta_r <= store_reset_n;
			linkRun_r <= linkRunMeta_r;
		end
	end

	always_comb begin
		if (!linkRun_r) begin
			wrPtr_nxt = `JAE_WPTR_RST;
		end else begin
			wrPtr_nxt = wrPtr_r + 4'h1;
		end
	end

	always_ff @(negedge line_clock_in or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_r <= `JAE_WPTR_RST;
			wrGray_r <= WR_GRAY_RST;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			wrGray_r <= toGray(wrPtr_nxt);
		end
	end

	// bit stored untouched, whatever its framing
	always_ff @(negedge line_clock_in) begin
		if (linkRun_r) begin
			storeMem[wrPtr_r] <= line_data_in;
		end
	end

	// ----------------------------------------
	// pin and pointer synchronisers into clk
	// ----------------------------------------
	jae_ptr_type wrGrayMeta_r;
	jae_ptr_type wrGraySync_r;
	logic runMeta_r;
	logic run_r;
	logic clearMeta_r;
	logic clearN_r;
	logic rateMeta_r;
	logic rate_r;

	// gray code lets only one bit move per write, so a torn sample is
	// at worst one position stale
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrGrayMeta_r <= WR_GRAY_RST;
			wrGraySync_r <= WR_GRAY_RST;
		end else begin
			wrGrayMeta_r <= wrGray_r;
			wrGraySync_r <= wrGrayMeta_r;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			runMeta_r <= 1'b0;
			run_r <= 1'b0;
			clearMeta_r <= 1'b0;
			clearN_r <= 1'b0;
			rateMeta_r <= 1'b0;
			rate_r <= 1'b0;
		end else begin
			runMeta_r <= store_reset_n;
			run_r <= runMeta_r;
			clearMeta_r <= flag_clear_n;
			clearN_r <= clearMeta_r;
			rateMeta_r <= rate_select;
			rate_r <= rateMeta_r;
		end
	end

	// ----------------------------------------
	// occupancy
	// ----------------------------------------
	jae_ptr_type rdPtr_r;
	jae_ptr_type wrSeen;
	jae_ptr_type occ;
	jae_ptr_type occPrev_r;
	logic risePulse;
	logic fallPulse;
	logic underflow;
	logic overflow;
	logic slipEvent;

	assign wrSeen = fromGray(wrGraySync_r);
	assign occ = wrSeen - rdPtr_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			occPrev_r <= `JAE_OCC_EMPTY;
		end else begin
			occPrev_r <= occ;
		end
	end

	// reading an empty store, or the writer lapping the reader
	// no relock on underflow: the reader laps and the next bits are invalid
	assign underflow = run_r & fallPulse & (occ == `JAE_OCC_EMPTY);
	assign overflow = run_r & ~fallPulse & (occPrev_r == `JAE_OCC_TOP)
		& (occ == `JAE_OCC_EMPTY);
	assign slipEvent = underflow | overflow;

	// ----------------------------------------
	// oscillator steering
	// ----------------------------------------
	jae_ctrl_type state_r;
	jae_step_type step_r;
	logic [CNT_W-1:0] bitCount_r;
	logic countDone;

	assign countDone = (bitCount_r == CNT_W'(UPDATE_BITS - 1));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= CTRL_HOLD;
		end else begin
			case (state_r)
				CTRL_HOLD: begin
					if (run_r) begin
						state_r <= CTRL_TRACK;
					end
				end
				CTRL_TRACK: begin
					if (!run_r) begin
						state_r <= CTRL_HOLD;
					end else if (fallPulse && countDone) begin
						state_r <= CTRL_ADJUST;
					end
				end
				CTRL_ADJUST: begin
					state_r <= run_r ? CTRL_TRACK : CTRL_HOLD;
				end
				default: begin
					state_r <= CTRL_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bitCount_r <= '0;
		end else if (state_r != CTRL_TRACK) begin
			bitCount_r <= '0;
		end else if (fallPulse) begin
			bitCount_r <= bitCount_r + CNT_W'(1);
		end
	end

	// one step per update keeps the loop slow, so fast jitter stays in
	// the store while slow wander is followed; dithering between steps
	// gives the input's average rate
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			step_r <= '0;
		end else if (state_r == CTRL_ADJUST) begin
			if (occ > `JAE_HALF_FULL && step_r < 3'sd`JAE_STEPS_EACH_SIDE) begin
				step_r <= step_r + 3'sd1;
			end else if (occ < `JAE_HALF_FULL
					&& step_r > -3'sd`JAE_STEPS_EACH_SIDE) begin
				step_r <= step_r - 3'sd1;
			end
		end
	end

	jae_word_type freqWord_r;

	// steps span the full pull range on each side of nominal
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			freqWord_r <= FREQ_RST;
		end else begin
			freqWord_r <= freqFor(rate_r, step_r);
		end
	end

	jae_nco oscillator (
		.clk(clk),
		.sys_rst(sys_rst),
		.hold(~run_r),
		.freqWord(freqWord_r),
		.risePulse(risePulse),
		.fallPulse(fallPulse)
	);

	// ----------------------------------------
	// read side
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdPtr_r <= `JAE_RPTR_RST;
		end else if (!run_r) begin
			rdPtr_r <= `JAE_RPTR_RST;
		end else if (overflow) begin
			// relock: put the reader back half a store behind the writer
			rdPtr_r <= wrSeen - `JAE_HALF_FULL;
		end else if (fallPulse) begin
			rdPtr_r <= rdPtr_r + 4'h1;
		end
	end

	// data moves on the falling edge so it is settled half a bit before
	// the next rising edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			line_data_out <= 1'b0;
		end else if (run_r && fallPulse) begin
			line_data_out <= storeMem[rdPtr_r];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dejittered_clock <= 1'b0;
		end else if (!run_r) begin
			dejittered_clock <= 1'b0;
		end else if (risePulse) begin
			dejittered_clock <= 1'b1;
		end else if (fallPulse) begin
			dejittered_clock <= 1'b0;
		end
	end

	// ----------------------------------------
	// slip flag
	// ----------------------------------------
	// a low clear pin disables the flag, so the clear wins over a slip
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			slip_flag <= 1'b0;
		end else if (!clearN_r) begin
			slip_flag <= 1'b0;
		end else if (slipEvent) begin
			slip_flag <= 1'b1;
		end
	end

endmodule

// ==== jae_elastic_store_tb.sv ====
// self-checking bench for the elastic store
// assumes the checker is bound and the line model drives the link side
`timescale 1ns/100ps

module jae_elastic_store_tb;
	localparam logic [31:0] PAT = 32'hF3A50C61;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rate_select = 1'b0;
	logic store_reset_n = 1'b0;
	logic flag_clear_n = 1'b1;
	logic lineRun = 1'b1;
	logic [15:0] halfTenths = 16'h0140;
	logic [15:0] jitTenths = 16'h0000;
	logic line_clock_in, line_data_in, dejittered_clock, line_data_out, slip_flag;
	int bad_count = 0;
	int num_checks = 0;
	int lineCnt = 0;
	int outCnt = 0;

	always #5 clk = ~clk;
	always @(negedge line_clock_in) lineCnt++;
	always @(posedge dejittered_clock) outCnt++;

	jae_line_src #(.PATTERN(PAT)) i_jae_line_src (.run(lineRun), .halfTenths(halfTenths),
		.jitTenths(jitTenths), .lineClock(line_clock_in), .lineData(line_data_in));
	// short update interval so steering is exercised within the run
	jae_elastic_store #(.UPDATE_BITS(8)) i_jae_elastic_store (.clk(clk), .sys_rst(sys_rst),
		.line_clock_in(line_clock_in), .line_data_in(line_data_in),
		.rate_select(rate_select), .store_reset_n(store_reset_n),
		.flag_clear_n(flag_clear_n), .dejittered_clock(dejittered_clock),
		.line_data_out(line_data_out), .slip_flag(slip_flag));

	task automatic chk(input logic [31:0] exp, input logic [31:0] act);
		num_checks++;
		if (act !== exp) begin
			bad_count++;
			$display("unexpected at %0t: expected %h got %h", $time, exp, act);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic t_start;
		ticks(4);
		chk(32'h0, {dejittered_clock, line_data_out, slip_flag});
		$display("t_start done");
	endtask

	task automatic t_pass(input logic rate, input logic [15:0] half);
		logic [31:0] outReg;
		logic found;
		int d;
		store_reset_n <= 1'b0;
		rate_select <= rate;
		halfTenths <= half;
		jitTenths <= 16'h0190;
		// store reset must span two falling line edges to reach the writer
		ticks(200);
		store_reset_n <= 1'b1;
		flag_clear_n <= 1'b0;
		ticks(5);
		flag_clear_n <= 1'b1;
		repeat (48) @(posedge dejittered_clock);
		lineCnt = 0;
		outCnt = 0;
		repeat (160) begin
			@(posedge dejittered_clock);
			outReg = {outReg[30:0], line_data_out};
		end
		found = 1'b0;
		for (int i = 0; i < 32; i++) begin
			if (outReg === 32'({PAT, PAT} >> i)) found = 1'b1;
		end
		chk(32'h1, found);
		d = lineCnt - outCnt;
		chk(32'h1, d <= 16 && d >= -16);
		chk(32'h0, slip_flag);
		$display("t_pass rate %0d done", rate);
	endtask

	task automatic t_slip;
		halfTenths <= 16'h0140;
		jitTenths <= 16'h0000;
		ticks(300);
		chk(32'h1, slip_flag);
		flag_clear_n <= 1'b0;
		ticks(4);
		chk(32'h0, slip_flag);
		ticks(100);
		chk(32'h0, slip_flag);
		flag_clear_n <= 1'b1;
		ticks(300);
		chk(32'h1, slip_flag);
		// stop the line: the reader drains the store and underflows
		flag_clear_n <= 1'b0;
		lineRun <= 1'b0;
		ticks(10);
		chk(32'h0, slip_flag);
		flag_clear_n <= 1'b1;
		ticks(1500);
		chk(32'h1, slip_flag);
		store_reset_n <= 1'b0;
		ticks(5);
		repeat (60) begin
			ticks(1);
			chk(32'h0, dejittered_clock);
		end
		$display("t_slip done");
	endtask

	initial begin
		// the tests need about 270 us; allow a little over twice that
		#600000;
		bad_count++;
		$display("watchdog expired at %0t", $time);
		final_report();
	end

	initial begin
		ticks(5);
		sys_rst <= 1'b0;
		t_start();
		t_pass(1'b1, 16'h0989);
		t_pass(1'b0, 16'h0CA6);
		t_slip();
		final_report();
	end
endmodule

// ==== jae_es_asserts.sv ====
// port checker for the elastic store
// assumes binding to jae_elastic_store; sees only its ports
`timescale 1ns/100ps

module jae_es_asserts #(
	parameter int UPDATE_BITS = 64
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic line_clock_in,
	input wire logic line_data_in,
	input wire logic rate_select,
	input wire logic store_reset_n,
	input wire logic flag_clear_n,
	input wire logic dejittered_clock,
	input wire logic line_data_out,
	input wire logic slip_flag
);
	// ----------------------------------------
	// high phase length of the output clock
	// ----------------------------------------
	logic [7:0] hiCnt_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hiCnt_r <= 8'h00;
		end else begin
			hiCnt_r <= dejittered_clock ? hiCnt_r + 8'h01 : 8'h00;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_srstHeld; !store_reset_n[*5]; endsequence
	sequence s_clrHeld; !flag_clear_n[*4]; endsequence
	sequence s_quietStart; !dejittered_clock[*8]; endsequence

	property p_clkLowInReset; s_srstHeld |-> !dejittered_clock; endproperty
	a_clkLowInReset: assert property (p_clkLowInReset) else $error("clock high in store reset");
	property p_readHeld; s_srstHeld ##1 !store_reset_n |-> $stable(line_data_out); endproperty
	a_readHeld: assert property (p_readHeld) else $error("data moved in store reset");
	property p_quietStart; $rose(store_reset_n) |-> s_quietStart; endproperty
	a_quietStart: assert property (p_quietStart) else $error("clock rose too early");
	property p_clearFlag; s_clrHeld |-> !slip_flag; endproperty
	a_clearFlag: assert property (p_clearFlag) else $error("flag not cleared");
	property p_flagHolds;
		$fell(slip_flag) |-> !$past(flag_clear_n, 2) || !$past(flag_clear_n, 3) ||
			!$past(flag_clear_n, 4);
	endproperty
	a_flagHolds: assert property (p_flagHolds) else $error("flag fell without clear");
	property p_flagRise; $rose(slip_flag) |-> $past(flag_clear_n, 3); endproperty
	a_flagRise: assert property (p_flagRise) else $error("flag set while clear held");
	property p_dataAtLow; $changed(line_data_out) |-> !dejittered_clock; endproperty
	a_dataAtLow: assert property (p_dataAtLow) else $error("data moved while clock high");
	// the high phase tells the selected nominal rate apart; pulling is far below a cycle
	property p_hiLen;
		$fell(dejittered_clock) && store_reset_n && $past(store_reset_n, 4) |->
			(rate_select ? hiCnt_r inside {[22:27]} : hiCnt_r inside {[30:35]});
	endproperty
	a_hiLen: assert property (p_hiLen) else $error("output clock rate wrong");
endmodule

bind jae_elastic_store jae_es_asserts #(.UPDATE_BITS(UPDATE_BITS)) i_jae_es_asserts (
	.clk(clk), .sys_rst(sys_rst), .line_clock_in(line_clock_in),
	.line_data_in(line_data_in), .rate_select(rate_select),
	.store_reset_n(store_reset_n), .flag_clear_n(flag_clear_n),
	.dejittered_clock(dejittered_clock), .line_data_out(line_data_out),
	.slip_flag(slip_flag)
);

// ==== jae_line_src.sv ====
// line receiver model: jittered line clock with a repeating bit pattern
// assumes the bench sets the half period and the jitter in tenths of a ns
`timescale 1ns/100ps

module jae_line_src #(
	parameter logic [31:0] PATTERN = 32'hF3A50C61
) (
	input wire logic run,
	input wire logic [15:0] halfTenths,
	input wire logic [15:0] jitTenths,
	output logic lineClock,
	output logic lineData
);
	int idx = 0;
	int halfNow = 0;
	initial begin
		lineClock = 1'b1;
		lineData = 1'b0;
	end
	// data moves on the rising edge, half a bit away from the sampling edge;
	// sixteen short bits then sixteen long ones give phase jitter of a few
	// unit intervals while the average rate stays put
	always begin
		if (run) begin
			halfNow = (idx < 16) ? halfTenths - jitTenths : halfTenths + jitTenths;
			#(halfNow / 10.0) lineClock = 1'b0;
			#(halfNow / 10.0) lineClock = 1'b1;
			lineData = PATTERN[31 - idx];
			idx = (idx + 1) % 32;
		end else begin
			// an idle line shows no stale bit
			#10 lineData = ~lineData;
		end
	end
endmodule

// ==== jae_nco.sv ====
// numerically controlled oscillator standing in for the pulled crystal
// assumes the frequency word is stable on clk; emits one-cycle edge strobes
`timescale 1ns/100ps
`include "jae_cfg.svh"

module jae_nco (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hold,
	input wire jae_pkg::jae_word_type freqWord,
	output logic risePulse,
	output logic fallPulse
);
	import jae_pkg::*;

	jae_word_type acc_r;
	logic msb_r;

	// ----------------------------------------
	// phase accumulator
	// ----------------------------------------
	// phase restarts at zero on release so the first output cycle is whole
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_r <= '0;
		end else if (hold) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_r + freqWord;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			msb_r <= 1'b0;
		end else begin
			msb_r <= acc_r[`JAE_ACC_W-1];
		end
	end

	assign risePulse = acc_r[`JAE_ACC_W-1] & ~msb_r;
	assign fallPulse = ~acc_r[`JAE_ACC_W-1] & msb_r;

endmodule

// ==== jae_pkg.sv ====
// types shared by the elastic store and its oscillator
// assumes jae_cfg.svh sits in the same folder
`include "jae_cfg.svh"

package jae_pkg;

	typedef enum logic [1:0] {
		CTRL_HOLD = 2'b00,
		CTRL_TRACK = 2'b01,
		CTRL_ADJUST = 2'b10
	} jae_ctrl_type;

	typedef logic [`JAE_PTR_W-1:0] jae_ptr_type;
	typedef logic signed [2:0] jae_step_type;
	typedef logic [`JAE_ACC_W-1:0] jae_word_type;

endpackage
